// ### logic/sqc_pkg.sv
// Package for the sequence run/stop control block: register map, field
// positions, reset values, codes and timing counts.
// Assumes a 200 MHz clock and a classic Wishbone slave with 32-bit data.
package sqc_pkg;
  // Register byte addresses
  localparam logic [8:0] A_FEAT  = 9'h000;
  localparam logic [8:0] A_LOCK  = 9'h004;
  localparam logic [8:0] A_FKEY  = 9'h008;
  localparam logic [8:0] A_STAT  = 9'h00c;
  localparam logic [8:0] A_IST   = 9'h010;
  localparam logic [8:0] A_IMSK  = 9'h014;
  localparam logic [8:0] A_ECODE = 9'h018;
  localparam logic [8:0] A_EDET  = 9'h01c;
  localparam logic [8:0] A_AUTO  = 9'h020;
  localparam logic [8:0] A_TOOL  = 9'h024;
  localparam logic [8:0] A_UPAR  = 9'h100;
  localparam logic [6:0] UPAR_N  = 7'h32;
  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  // Setting codes
  localparam logic [15:0] FEAT_OFF   = 16'h0000;
  localparam logic [15:0] FEAT_1     = 16'h0001;
  localparam logic [15:0] FEAT_2     = 16'h0002;
  localparam logic [15:0] FEAT_11    = 16'h000b;
  localparam logic [15:0] FEAT_12    = 16'h000c;
  localparam logic [15:0] LOCK_OFF   = 16'h0000;
  localparam logic [15:0] LOCK_ON    = 16'h0001;
  localparam logic [15:0] FKEY_MAX   = 16'h270f;
  localparam logic [15:0] FKEY_CLEAR = 16'h25e0;
  localparam logic [15:0] ERR_UNSUP  = 16'h0fa0;
  // Status register bits
  localparam int STAT_RUN   = 0;
  localparam int STAT_ERR   = 1;
  localparam int STAT_DECEL = 2;
  localparam int STAT_EN    = 3;
  // Tool register bits
  localparam int TOOL_FWD   = 0;
  localparam int TOOL_REV   = 1;
  localparam int TOOL_FORCE = 8;
  // Interrupt event bits
  localparam int EV_RUN     = 0;
  localparam int EV_STOP    = 1;
  localparam int EV_ERR     = 2;
  localparam int EV_REFUSE  = 3;
  localparam int EV_LOCKREJ = 4;
  localparam int EV_FLASH   = 5;
  localparam int EV_W       = 6;
  localparam int OUT_W      = 8;
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int RES_HOLD_NS   = 100000000;
  localparam int RES_HOLD_CYC  = (RES_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RES_CNT_W     = 25;
  // Program execution states
  typedef enum logic [1:0] {
    SQC_STOP = 2'b01,
    SQC_RUN  = 2'b10
  } sqc_state_t;
endpackage

// ### logic/sqc_upar_mem.sv
// User parameter store: fifty 16-bit words, all zero after reset.
// Assumes one access per cycle; read data appear one cycle after the address.
`timescale 1ns/10ps
`default_nettype none
module sqc_upar_mem (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  output logic      [15:0] rdata_o
);
  typedef struct packed {
    logic [49:0][15:0] mem;
    logic [15:0]       rd;
  } sqc_mem_t;

  sqc_mem_t s_r;
  sqc_mem_t s_nxt;

  // Addresses past the last word read zero and drop writes
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rd = sqc_pkg::RST_WORD;
    if ({1'b0, addr_i} < sqc_pkg::UPAR_N)
    begin
      s_nxt.rd = s_r.mem[addr_i];
      if (we_i)
        s_nxt.mem[addr_i] = wdata_i;
    end
  end

  // Whole array resets so every parameter starts at zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_r <= '0;
    else if (ce_i)
      s_r <= s_nxt;
  end

  assign rdata_o = s_r.rd;
endmodule
`default_nettype wire

// ### logic/sqc_run_ctrl.sv
// Sequence program run/stop control with start lock, error capture and
// user parameter store behind a classic Wishbone slave.
// Assumes all inputs synchronous to clk_i and scan_tick_i one pulse per scan.
//
// Our own choices: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module sqc_run_ctrl #(
  parameter int RES_HOLD_CYC = sqc_pkg::RES_HOLD_CYC
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  input  wire logic                     cyc_i,
  input  wire logic                     stb_i,
  input  wire logic                     we_i,
  input  wire logic [8:0]               adr_i,
  input  wire logic [31:0]              dat_i,
  input  wire logic [3:0]               sel_i,
  output logic      [31:0]              dat_o,
  output logic                          ack_o,
  output logic                          irq_o,
  input  wire logic                     scan_tick_i,
  input  wire logic                     program_run_request_i,
  input  wire logic                     forward_start_input_i,
  input  wire logic                     reverse_start_input_i,
  input  wire logic                     panel_forward_start_i,
  input  wire logic                     panel_reverse_start_i,
  input  wire logic                     drive_reset_input_i,
  input  wire logic                     motor_running_i,
  input  wire logic [sqc_pkg::OUT_W-1:0] program_out_i,
  input  wire logic                     unsupported_exec_i,
  input  wire logic [15:0]              error_detail_i,
  input  wire logic                     tool_access_req_i,
  output logic                          tool_access_refused_o,
  output logic                          program_run_o,
  output logic      [sqc_pkg::OUT_W-1:0] program_out_o,
  output logic      [sqc_pkg::OUT_W-1:0] saved_out_o,
  output logic      [1:0]               program_terminal_o,
  output logic                          forward_start_o,
  output logic                          reverse_start_o,
  output logic                          decel_stop_o,
  output logic      [15:0]              auto_operation_command_word_o,
  output logic                          error_flag_relay_o,
  output logic      [15:0]              error_code_register_o,
  output logic      [15:0]              error_detail_registers_o,
  output logic                          device_clear_o,
  output logic                          flash_clear_o
);
  typedef struct packed {
    sqc_pkg::sqc_state_t       st;
    logic [15:0]               feat;
    logic [15:0]               lock;
    logic [15:0]               fkey;
    logic [sqc_pkg::EV_W-1:0]  ist;
    logic [sqc_pkg::EV_W-1:0]  imsk;
    logic [15:0]               ecode;
    logic [15:0]               edet;
    logic                      relay;
    logic [15:0]               auto_w;
    logic [15:0]               tool;
    logic [sqc_pkg::OUT_W-1:0] pout;
    logic [sqc_pkg::OUT_W-1:0] psave;
    logic                      fwd;
    logic                      rev;
    logic                      decel;
    logic [15:0]               aout;
    logic [sqc_pkg::RES_CNT_W-1:0] rcnt;
    logic                      rheld;
    logic                      clr;
    logic                      flash;
    logic                      ack;
    logic                      upsel;
    logic [31:0]               rdat;
  } sqc_regs_t;

  sqc_regs_t s_r;
  sqc_regs_t s_nxt;

  logic [15:0] up_rdata;
  logic [8:0]  up_off;
  logic        up_hit;
  logic        req;
  logic        wr;
  logic        run_now;
  logic        start_ok;
  logic [15:0] wv;

  localparam logic [sqc_pkg::RES_CNT_W-1:0] HOLD_LAST = sqc_pkg::RES_CNT_W'(RES_HOLD_CYC - 1);

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] nw,
                                             input logic [1:0] sel);
    lane_merge = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction

  // Legal program feature codes
  function automatic logic feat_legal(input logic [15:0] v);
    feat_legal = (v == sqc_pkg::FEAT_OFF) || (v == sqc_pkg::FEAT_1) || (v == sqc_pkg::FEAT_2) ||
                 (v == sqc_pkg::FEAT_11) || (v == sqc_pkg::FEAT_12);
  endfunction

  // Bus request decode; ack doubles as a one-cycle busy so each request is taken once
  assign req    = cyc_i && stb_i && !s_r.ack;
  assign wr     = req && we_i;
  assign up_off = adr_i - sqc_pkg::A_UPAR;
  assign up_hit = (adr_i >= sqc_pkg::A_UPAR) && ({2'b00, up_off[8:2]} < {2'b00, sqc_pkg::UPAR_N});
  assign wv     = lane_merge(16'h0000, dat_i[15:0], sel_i[1:0]);
  assign run_now = (s_r.st == sqc_pkg::SQC_RUN);
  // Lock at one opens the start gate only during program run
  assign start_ok = (s_r.lock == sqc_pkg::LOCK_ON) ? run_now : 1'b1;

  sqc_upar_mem u_upar (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .we_i    (wr && up_hit && (sel_i[1:0] == 2'b11)),
    .addr_i  (up_off[7:2]),
    .wdata_i (dat_i[15:0]),
    .rdata_o (up_rdata)
  );

  // Next-state logic for the whole block
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ack = req;
    s_nxt.clr = 1'b0;
    s_nxt.flash = 1'b0;
    // Clear first so an event in the same cycle still sets its bit
    if (wr && (adr_i == sqc_pkg::A_IST))
      s_nxt.ist = s_r.ist & ~wv[sqc_pkg::EV_W-1:0];
    // Run state follows the request only at scan boundaries
    if (s_r.feat == sqc_pkg::FEAT_OFF)
      s_nxt.st = sqc_pkg::SQC_STOP;
    else if (scan_tick_i)
      s_nxt.st = program_run_request_i ? sqc_pkg::SQC_RUN : sqc_pkg::SQC_STOP;
    // Outputs track the program in run; on stop they are saved and forced off
    case (s_r.st)
      sqc_pkg::SQC_RUN:
      begin
        if (s_nxt.st == sqc_pkg::SQC_STOP)
        begin
          s_nxt.psave = s_r.pout;
          s_nxt.pout = '0;
          s_nxt.ist[sqc_pkg::EV_STOP] = 1'b1;
          if ((s_r.lock == sqc_pkg::LOCK_ON) && motor_running_i)
            s_nxt.decel = 1'b1;
        end
        else
          s_nxt.pout = program_out_i;
      end
      sqc_pkg::SQC_STOP:
      begin
        s_nxt.pout = '0;
        if (s_nxt.st == sqc_pkg::SQC_RUN)
          s_nxt.ist[sqc_pkg::EV_RUN] = 1'b1;
      end
      default:
        s_nxt.st = sqc_pkg::SQC_STOP;
    endcase
    if (!motor_running_i)
      s_nxt.decel = 1'b0;
    // Terminal and panel starts share one gate; tool mirrors never reach it
    s_nxt.fwd = (forward_start_input_i || panel_forward_start_i) && start_ok && !s_nxt.decel;
    s_nxt.rev = (reverse_start_input_i || panel_reverse_start_i) && start_ok && !s_nxt.decel;
    // Automatic command word is cut on stop only under the lock
    s_nxt.aout = (run_now || (s_r.lock != sqc_pkg::LOCK_ON)) ? s_r.auto_w : sqc_pkg::RST_WORD;
    // Unsupported instruction capture; other devices are left untouched
    if (unsupported_exec_i && run_now)
    begin
      s_nxt.ecode = sqc_pkg::ERR_UNSUP;
      s_nxt.edet = error_detail_i;
      s_nxt.relay = 1'b1;
      s_nxt.ist[sqc_pkg::EV_ERR] = 1'b1;
    end
    if (tool_access_req_i && run_now)
      s_nxt.ist[sqc_pkg::EV_REFUSE] = 1'b1;
    // Long drive reset press, then release, clears retained device data
    if (drive_reset_input_i)
    begin
      if (s_r.rcnt != HOLD_LAST)
        s_nxt.rcnt = s_r.rcnt + 1'b1;
      else
        s_nxt.rheld = 1'b1;
    end
    else
    begin
      s_nxt.rcnt = '0;
      s_nxt.rheld = 1'b0;
      if (s_r.rheld)
      begin
        s_nxt.clr = 1'b1;
        s_nxt.psave = '0;
        s_nxt.relay = 1'b0;
        s_nxt.ecode = sqc_pkg::RST_WORD;
        s_nxt.edet = sqc_pkg::RST_WORD;
      end
    end
    // Register writes
    if (wr)
    begin
      case (adr_i)
        sqc_pkg::A_FEAT:
          if (feat_legal(lane_merge(s_r.feat, dat_i[15:0], sel_i[1:0])))
            s_nxt.feat = lane_merge(s_r.feat, dat_i[15:0], sel_i[1:0]);
        sqc_pkg::A_LOCK:
          if (motor_running_i || (lane_merge(s_r.lock, dat_i[15:0], sel_i[1:0]) > sqc_pkg::LOCK_ON))
            s_nxt.ist[sqc_pkg::EV_LOCKREJ] = 1'b1;
          else
            s_nxt.lock = lane_merge(s_r.lock, dat_i[15:0], sel_i[1:0]);
        sqc_pkg::A_FKEY:
          if (lane_merge(s_r.fkey, dat_i[15:0], sel_i[1:0]) <= sqc_pkg::FKEY_MAX)
          begin
            s_nxt.fkey = lane_merge(s_r.fkey, dat_i[15:0], sel_i[1:0]);
            if (s_nxt.fkey == sqc_pkg::FKEY_CLEAR)
            begin
              s_nxt.flash = 1'b1;
              s_nxt.ist[sqc_pkg::EV_FLASH] = 1'b1;
            end
          end
        sqc_pkg::A_IMSK:
          s_nxt.imsk = sel_i[0] ? dat_i[sqc_pkg::EV_W-1:0] : s_r.imsk; // All mask bits sit in the low lane
        sqc_pkg::A_AUTO:
          s_nxt.auto_w = lane_merge(s_r.auto_w, dat_i[15:0], sel_i[1:0]);
        sqc_pkg::A_TOOL:
          s_nxt.tool = lane_merge(s_r.tool, dat_i[15:0], sel_i[1:0]);
        default:
          s_nxt.tool = s_nxt.tool;
      endcase
    end
    // Read data registered with ack; unmapped addresses read zero
    s_nxt.upsel = req && up_hit;
    s_nxt.rdat = 32'h0000_0000;
    if (req && !we_i)
    begin
      case (adr_i)
        sqc_pkg::A_FEAT:  s_nxt.rdat[15:0] = s_r.feat;
        sqc_pkg::A_LOCK:  s_nxt.rdat[15:0] = s_r.lock;
        sqc_pkg::A_FKEY:  s_nxt.rdat[15:0] = s_r.fkey;
        sqc_pkg::A_STAT:
        begin
          s_nxt.rdat[sqc_pkg::STAT_RUN] = run_now;
          s_nxt.rdat[sqc_pkg::STAT_ERR] = s_r.relay;
          s_nxt.rdat[sqc_pkg::STAT_DECEL] = s_r.decel;
          s_nxt.rdat[sqc_pkg::STAT_EN] = (s_r.feat != sqc_pkg::FEAT_OFF);
        end
        sqc_pkg::A_IST:   s_nxt.rdat[sqc_pkg::EV_W-1:0] = s_r.ist;
        sqc_pkg::A_IMSK:  s_nxt.rdat[sqc_pkg::EV_W-1:0] = s_r.imsk;
        sqc_pkg::A_ECODE: s_nxt.rdat[15:0] = s_r.ecode;
        sqc_pkg::A_EDET:  s_nxt.rdat[15:0] = s_r.edet;
        sqc_pkg::A_AUTO:  s_nxt.rdat[15:0] = s_r.auto_w;
        sqc_pkg::A_TOOL:  s_nxt.rdat[15:0] = s_r.tool;
        default:          s_nxt.rdat = 32'h0000_0000;
      endcase
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r <= '0;
      s_r.st <= sqc_pkg::SQC_STOP;
    end
    else if (ce_i)
      s_r <= s_nxt;
  end

  // Output drive
  assign ack_o = s_r.ack;
  assign dat_o = s_r.upsel ? {16'h0000, up_rdata} : s_r.rdat;
  assign irq_o = |(s_r.ist & s_r.imsk);
  assign tool_access_refused_o = tool_access_req_i && run_now;
  assign program_run_o = run_now;
  assign program_out_o = s_r.pout;
  assign saved_out_o = s_r.psave;
  // Tool force changes only what the program sees
  assign program_terminal_o = s_r.tool[sqc_pkg::TOOL_FORCE] ?
                              {s_r.tool[sqc_pkg::TOOL_REV], s_r.tool[sqc_pkg::TOOL_FWD]} :
                              {reverse_start_input_i, forward_start_input_i};
  assign forward_start_o = s_r.fwd;
  assign reverse_start_o = s_r.rev;
  assign decel_stop_o = s_r.decel;
  assign auto_operation_command_word_o = s_r.aout;
  assign error_flag_relay_o = s_r.relay;
  assign error_code_register_o = s_r.ecode;
  assign error_detail_registers_o = s_r.edet;
  assign device_clear_o = s_r.clr;
  assign flash_clear_o = s_r.flash;

  // Checks
  sequence s_stop_edge;
    run_now && (s_nxt.st == sqc_pkg::SQC_STOP) && ce_i;
  endsequence
  sequence s_wb_answer;
    ack_o ##1 !ack_o;
  endsequence
  property p_feat_off;
    @(posedge clk_i) disable iff (rst_i)
    (s_r.feat == sqc_pkg::FEAT_OFF) && ce_i |=> !program_run_o;
  endproperty
  a_feat_off: assert property (p_feat_off) else $error("Program ran while disabled");
  property p_scan_only;
    @(posedge clk_i) disable iff (rst_i)
    $rose(program_run_o) |-> $past(scan_tick_i) && $past(program_run_request_i);
  endproperty
  a_scan_only: assert property (p_scan_only) else $error("Run began off a scan boundary");
  property p_stop_save;
    @(posedge clk_i) disable iff (rst_i)
    s_stop_edge |=> (program_out_o == '0) && (saved_out_o == $past(program_out_o));
  endproperty
  a_stop_save: assert property (p_stop_save) else $error("Outputs not saved and cleared on stop");
  property p_lock_block;
    @(posedge clk_i) disable iff (rst_i)
    (s_r.lock == sqc_pkg::LOCK_ON) && !run_now && ce_i |=> !forward_start_o && !reverse_start_o;
  endproperty
  a_lock_block: assert property (p_lock_block) else $error("Start passed while locked");
  property p_nolock_pass;
    @(posedge clk_i) disable iff (rst_i)
    (s_r.lock == sqc_pkg::LOCK_OFF) && panel_forward_start_i && !s_nxt.decel && ce_i |=> forward_start_o;
  endproperty
  a_nolock_pass: assert property (p_nolock_pass) else $error("Start blocked with lock off");
  property p_decel;
    @(posedge clk_i) disable iff (rst_i)
    s_stop_edge ##0 (s_r.lock == sqc_pkg::LOCK_ON) && motor_running_i |=> decel_stop_o && !forward_start_o;
  endproperty
  a_decel: assert property (p_decel) else $error("No deceleration on stop under lock");
  property p_lock_wr_run;
    @(posedge clk_i) disable iff (rst_i)
    wr && (adr_i == sqc_pkg::A_LOCK) && motor_running_i && ce_i |=> $stable(s_r.lock);
  endproperty
  a_lock_wr_run: assert property (p_lock_wr_run) else $error("Lock written while running");
  property p_err;
    @(posedge clk_i) disable iff (rst_i)
    unsupported_exec_i && run_now && ce_i |=> error_flag_relay_o && (error_code_register_o == sqc_pkg::ERR_UNSUP);
  endproperty
  a_err: assert property (p_err) else $error("Error capture missing");
  property p_flash;
    @(posedge clk_i) disable iff (rst_i)
    flash_clear_o |-> $past(wr) && ($past(adr_i) == sqc_pkg::A_FKEY) && (s_r.fkey == sqc_pkg::FKEY_CLEAR);
  endproperty
  a_flash: assert property (p_flash) else $error("Flash clear without key");
  property p_wb;
    @(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o && ce_i ##1 ce_i |-> s_wb_answer;
  endproperty
  a_wb: assert property (p_wb) else $error("Bus answer not one cycle");
endmodule
`default_nettype wire

// ### bench/sqc_drive_model.sv
// Behavioural model of the drive side: run-request terminal and a motor.
// Assumes start commands arrive as levels synchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none
module sqc_drive_model #(
  parameter int TERM_FUNC = 50,
  parameter int DECEL_CYC = 6
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic term_level_i,
  input  wire logic fwd_i,
  input  wire logic rev_i,
  input  wire logic decel_i,
  output logic      run_req_o,
  output logic      motor_running_o
);
  int cnt;
  // Terminal drives the run request only with function code 50
  assign run_req_o = (TERM_FUNC == 50) ? term_level_i : 1'b0;
  // Motor coasts for a few cycles, so a stop is never instant
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt <= 0;
    else if ((fwd_i | rev_i) && !decel_i)
      cnt <= DECEL_CYC;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
  assign motor_running_o = (cnt != 0);
endmodule
`default_nettype wire

// ### bench/test_sequence_run_stop_control.sv
// Self-checking bench for the run/stop control block.
// Assumes the drive model beside it and a 200 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module test_sequence_run_stop_control;
  logic        clk_i, rst_i, cyc, stb, we, tick, term, tf, tr, pf, pr, dres, unsup, treq;
  logic        ack_o, irq_o, refused, run_o, fwd_o, rev_o, decel_o, relay_o, dclr_o, fclr_o, req, mot, seen;
  logic [8:0]  adr;
  logic [31:0] dat, dat_o, q, seed;
  logic [3:0]  sel;
  logic [7:0]  pout, pout_o, saved_o;
  logic [15:0] edet, auto_o, ecode_o, edet_o, w, key;
  logic [1:0]  pterm;
  int          n_mismatch, compares, k;
  int          n_flash = 0;
  logic [15:0] feats [4] = '{16'h0001, 16'h0002, 16'h000b, 16'h000c};

  sqc_run_ctrl #(.RES_HOLD_CYC(8)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .dat_i(dat), .sel_i(sel), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .scan_tick_i(tick),
    .program_run_request_i(req), .forward_start_input_i(tf), .reverse_start_input_i(tr),
    .panel_forward_start_i(pf), .panel_reverse_start_i(pr), .drive_reset_input_i(dres),
    .motor_running_i(mot), .program_out_i(pout), .unsupported_exec_i(unsup), .error_detail_i(edet),
    .tool_access_req_i(treq), .tool_access_refused_o(refused), .program_run_o(run_o),
    .program_out_o(pout_o), .saved_out_o(saved_o), .program_terminal_o(pterm), .forward_start_o(fwd_o),
    .reverse_start_o(rev_o), .decel_stop_o(decel_o), .auto_operation_command_word_o(auto_o),
    .error_flag_relay_o(relay_o), .error_code_register_o(ecode_o), .error_detail_registers_o(edet_o),
    .device_clear_o(dclr_o), .flash_clear_o(fclr_o));
  sqc_drive_model drv (.clk_i(clk_i), .rst_i(rst_i), .term_level_i(term), .fwd_i(fwd_o), .rev_i(rev_o),
    .decel_i(decel_o), .run_req_o(req), .motor_running_o(mot));

  // Clock at 5 ns
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Count flash clear pulses; a pulse that stands too long counts twice
  always @(posedge clk_i)
  begin
    if (fclr_o === 1'b1)
      n_flash <= n_flash + 1;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected flash key after a write: out-of-range values leave it alone
  function automatic logic [15:0] key_exp(input logic [15:0] old, input logic [15:0] v);
    return (v <= sqc_pkg::FKEY_MAX) ? v : old;
  endfunction
  // Expected gated start for a held start input
  function automatic logic start_exp(input logic lock, input logic run);
    return lock ? run : 1'b1;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("mismatches=%0d compares=%0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Classic cycle: hold everything until ack is sampled, then one idle cycle
  task automatic bus(input logic w_, input logic [8:0] a, input logic [31:0] d);
    int j;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_;
    adr <= a;
    dat <= d;
    j = 0;
    do
    begin
      @(posedge clk_i);
      j++;
    end
    while (ack_o !== 1'b1 && j < 20);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    if (j >= 20)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  task automatic scan(input logic r);
    term <= r;
    @(posedge clk_i);
    tick <= 1'b1;
    @(posedge clk_i);
    tick <= 1'b0;
    @(posedge clk_i);
  endtask
  // Wait for the motor to come to rest, bounded
  task automatic rest();
    for (k = 0; k < 50 && mot === 1'b1; k++)
      @(posedge clk_i);
    chk(mot, 1'b0);
  endtask

  initial
  begin
    {cyc, stb, we, tick, term, tf, tr, pf, pr, dres, unsup, treq} = '0;
    adr = '0;
    dat = '0;
    sel = 4'hf;
    pout = '0;
    edet = '0;
    rst_i = 1'b1;
    seed = 32'hac7424ac;
    n_mismatch = 0;
    compares = 0;
    cy(5);
    rst_i <= 1'b0;
    cy(1);
    // Reset values, an unmapped hole, then random user parameters
    foreach (feats[i])
    begin
      bus(1'b0, (i == 3) ? 9'h1c4 : 9'(4 * i), 32'h0);
      chk(q, 32'h0);
    end
    bus(1'b0, 9'h0fc, 32'h0);
    chk(q, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      k = (i == 0) ? 49 : rnd() % 50;
      w = 16'(rnd());
      bus(1'b1, sqc_pkg::A_UPAR + 9'(4 * k), {16'h0, w});
      bus(1'b0, sqc_pkg::A_UPAR + 9'(4 * k), 32'h0);
      chk(q, {16'h0, w});
    end
    $display("test regs done");
    // Feature zero blocks running; each legal value enables, illegal ignored
    scan(1'b1);
    chk(run_o, 1'b0);
    bus(1'b1, sqc_pkg::A_FEAT, 32'h3);
    bus(1'b0, sqc_pkg::A_FEAT, 32'h0);
    chk(q, 32'h0);
    foreach (feats[i])
    begin
      bus(1'b1, sqc_pkg::A_FEAT, {16'h0, feats[i]});
      scan(1'b1);
      chk(run_o, 1'b1);
      bus(1'b1, sqc_pkg::A_FEAT, 32'h0);
      chk(run_o, 1'b0);
    end
    $display("test feature done");
    // Request drops between scans; outputs saved and cleared at the scan
    bus(1'b1, sqc_pkg::A_FEAT, 32'h1);
    pout <= 8'(rnd()) | 8'h01;
    scan(1'b1);
    cy(1);
    chk(pout_o, pout);
    term <= 1'b0;
    cy(3);
    chk(run_o, 1'b1);
    scan(1'b0);
    chk(run_o, 1'b0);
    chk(pout_o, 8'h00);
    chk(saved_o, pout);
    $display("test stop done");
    // Lock on: starts refused in stop, pass in run, stop decelerates
    bus(1'b1, sqc_pkg::A_LOCK, 32'h2);
    bus(1'b1, sqc_pkg::A_LOCK, 32'h1);
    bus(1'b0, sqc_pkg::A_LOCK, 32'h0);
    chk(q, 32'h1);
    tf <= 1'b1;
    pr <= 1'b1;
    cy(2);
    chk(fwd_o, start_exp(1'b1, 1'b0));
    chk(rev_o, start_exp(1'b1, 1'b0));
    scan(1'b1);
    cy(1);
    chk(fwd_o, start_exp(1'b1, 1'b1));
    chk(rev_o, start_exp(1'b1, 1'b1));
    bus(1'b1, sqc_pkg::A_LOCK, 32'h0);
    bus(1'b0, sqc_pkg::A_LOCK, 32'h0);
    chk(q, 32'h1);
    w = 16'(rnd()) | 16'h1;
    bus(1'b1, sqc_pkg::A_AUTO, {16'h0, w});
    chk(auto_o, w);
    scan(1'b0);
    chk(decel_o, 1'b1);
    cy(1);
    chk(auto_o, 16'h0);
    {tf, pr} <= 2'b00;
    rest();
    cy(2);
    chk(decel_o, 1'b0);
    $display("test lock done");
    // Lock off: starts and the command word ignore the program state
    bus(1'b1, sqc_pkg::A_LOCK, 32'h0);
    {tr, pf} <= 2'b11;
    scan(1'b1);
    scan(1'b0);
    chk(fwd_o, start_exp(1'b0, 1'b0));
    chk(rev_o, start_exp(1'b0, 1'b0));
    chk(decel_o, 1'b0);
    chk(auto_o, w);
    {tr, pf} <= 2'b00;
    rest();
    $display("test unlock done");
    // Tool access refused in run; forced mirror never starts the drive
    scan(1'b1);
    treq <= 1'b1;
    bus(1'b1, sqc_pkg::A_TOOL, 32'h101);
    chk(refused, 1'b1);
    chk(pterm, 2'b01);
    chk(fwd_o, 1'b0);
    bus(1'b1, sqc_pkg::A_TOOL, 32'h0);
    treq <= 1'b0;
    // Unsupported instruction: code, detail, relay and a masked interrupt
    bus(1'b1, sqc_pkg::A_IMSK, 32'h0);
    edet <= 16'(rnd());
    unsup <= 1'b1;
    cy(1);
    unsup <= 1'b0;
    cy(2);
    chk(relay_o, 1'b1);
    chk(edet_o, edet);
    chk(ecode_o, sqc_pkg::ERR_UNSUP);
    chk(irq_o, 1'b0);
    bus(1'b0, sqc_pkg::A_ECODE, 32'h0);
    chk(q, {16'h0, sqc_pkg::ERR_UNSUP});
    bus(1'b1, sqc_pkg::A_IMSK, 32'h1 << sqc_pkg::EV_ERR);
    chk(irq_o, 1'b1);
    bus(1'b1, sqc_pkg::A_IST, 32'h1 << sqc_pkg::EV_ERR);
    chk(irq_o, 1'b0);
    scan(1'b0);
    chk(edet_o, edet);
    chk(relay_o, 1'b1);
    $display("test error done");
    // Flash key: range kept, only the key value clears
    key = 16'h0;
    bus(1'b1, sqc_pkg::A_FKEY, 32'h270f);
    key = key_exp(key, 16'h270f);
    bus(1'b0, sqc_pkg::A_IST, 32'h0);
    chk(q & 32'h20, 32'h0);
    chk(n_flash, 0);
    bus(1'b1, sqc_pkg::A_FKEY, 32'h2710);
    key = key_exp(key, 16'h2710);
    bus(1'b0, sqc_pkg::A_FKEY, 32'h0);
    chk(q, {16'h0, key});
    bus(1'b1, sqc_pkg::A_FKEY, {16'h0, sqc_pkg::FKEY_CLEAR});
    bus(1'b0, sqc_pkg::A_IST, 32'h0);
    chk(q & 32'h20, 32'h20);
    chk(n_flash, 1);
    $display("test flash done");
    // Short drive reset keeps data; a full hold then release clears it
    dres <= 1'b1;
    cy(3);
    dres <= 1'b0;
    cy(3);
    chk(relay_o, 1'b1);
    dres <= 1'b1;
    cy(10);
    dres <= 1'b0;
    seen = 1'b0;
    for (k = 0; k < 6; k++)
    begin
      @(posedge clk_i);
      seen = seen | (dclr_o === 1'b1);
    end
    chk(seen, 1'b1);
    chk(relay_o, 1'b0);
    chk(saved_o, 8'h00);
    $display("test clear done");
    wrap_up();
  end
endmodule
`default_nettype wire
